// >>> hw/dpdl_top.sv
// Direction detection, lock flag and mode change logic of the phase loop.
// Assumes TRIGGER, STATE, the direction channel and gap flag arrive asynchronously.
// Function
// - Run mode 0 is normal, 1 is emergency; normal-to-emergency switch handled.
// - After switch to emergency, next STATE slope loads state profile from trigger profile.
// - In emergency mode a direction change clears the lock flag.
// - Lock set again after four missing-state gaps, not the specified two.
// - Trigger-based direction compares threshold with active-to-inactive trigger duration.
// - Direction is evaluated at the inactive trigger edge in both methods.
// - Backward status bit: 1 backward, 0 forward.
// - Threshold zero holds the latest direction instead of forcing forward.
// - Maximum threshold makes the next evaluation switch to forward.
// - Input-based selection takes direction from direction channel when map select 0 and combined signal mode off.
// - Enable toggle 1-0-1 resets backward status, discarding a disturbed direction.
// - Toggle reset fails if no state seen and emergency entered afterwards.
// - During toggle internal direction held while status shows reset value.
`timescale 1ns/10ps
`default_nettype none
module dpdl_top
    import dpdl_pkg::*;
#(
    parameter int TS_W = `DPDL_TS_W,
    parameter int PROF_W = `DPDL_PROF_W
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Configuration
    input wire dpdl_cfg_s cfg_i,
    input wire logic [PROF_W-1:0] trigger_profile_value_i,
    // Input signals
    input wire logic trigger_i,
    input wire logic state_i,
    input wire logic direction_input_channel_i,
    input wire logic missing_state_flag_i,
    // Status
    output dpdl_stat_s stat_o,
    output logic internal_dir_o
);
    if (TS_W != `DPDL_TS_W || PROF_W != `DPDL_PROF_W) begin : g_width_chk
        $error("dpdl_top: widths must match the configuration header");
    end

    // ----------------------------------------------------------------
    // Reset release and input synchronisation
    // ----------------------------------------------------------------
    logic rst_m_r;
    logic rst_s_r;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_m_r <= 1'h0;
            rst_s_r <= 1'h0;
        end else begin
            rst_m_r <= 1'h1;
            rst_s_r <= rst_m_r;
        end
    end
    wire rst_b = rst_s_r;

    wire trg_lvl;
    wire trg_rise;
    wire trg_fall;
    wire st_rise;
    wire gap_rise;
    wire dir_in_lvl;
    dpdl_edge_sync u_trg (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .async_i(trigger_i),
        .level_o(trg_lvl), .rise_o(trg_rise), .fall_o(trg_fall));
    dpdl_edge_sync u_st (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .async_i(state_i),
        .level_o(), .rise_o(st_rise), .fall_o());
    dpdl_edge_sync u_gap (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b),
        .async_i(missing_state_flag_i), .level_o(), .rise_o(gap_rise), .fall_o());
    dpdl_edge_sync u_dir (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b),
        .async_i(direction_input_channel_i), .level_o(dir_in_lvl), .rise_o(), .fall_o());

    // ----------------------------------------------------------------
    // Enable toggle tracking
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {EN_OFF, EN_RUN, EN_PAUSE} dpdl_en_e;
    dpdl_en_e en_r;
    dpdl_en_e en_nxt;
    logic fsd_r;
    logic fsd_at_dis_r;
    logic mode_r;
    logic mode_at_dis_r;
    always_comb begin
        en_nxt = en_r;
        unique case (en_r)
            EN_OFF: if (cfg_i.enable) en_nxt = EN_RUN;
            EN_RUN: if (!cfg_i.enable) en_nxt = EN_PAUSE;
            EN_PAUSE: if (cfg_i.enable) en_nxt = EN_RUN;
        endcase
    end
    wire toggle_end = (en_r == EN_PAUSE) & cfg_i.enable;
    wire active = (en_r == EN_RUN);
    // Stale direction survives when no state was seen and emergency was entered while off
    wire reset_fails = ~fsd_at_dis_r & ~mode_at_dis_r & (mode_r == `DPDL_MODE_EMERG);
    wire mode_up = (cfg_i.run_mode_select == `DPDL_MODE_EMERG) & (mode_r == `DPDL_MODE_NORMAL);

    // ----------------------------------------------------------------
    // Direction detection
    // ----------------------------------------------------------------
    logic [TS_W-1:0] high_cnt_r;
    logic dir_r;
    logic bwd_r;
    logic lock_r;
    logic [`DPDL_GAP_W-1:0] gap_cnt_r;
    logic state_profile_value_pend_r;
    logic [PROF_W-1:0] state_profile_value_r;

    wire thr_zero = (cfg_i.min_high_threshold == `DPDL_THR_ZERO);
    wire thr_max = (cfg_i.min_high_threshold == `DPDL_THR_MAX);
    // Short high phase below threshold means backward; zero threshold holds
    wire thr_dir = thr_max ? `DPDL_DIR_FWD :
        (high_cnt_r < cfg_i.min_high_threshold) ? `DPDL_DIR_BWD : `DPDL_DIR_FWD;
    wire thr_valid = ~thr_zero;
    wire pin_valid = (cfg_i.trigger_map_select == `DPDL_MAP_DIRECT);
    wire use_pin = cfg_i.direction_source_select & ~cfg_i.combined_signal_mode;
    wire new_dir = use_pin ? dir_in_lvl : thr_dir;
    wire eval_ok = active & trg_fall & (use_pin ? pin_valid : thr_valid);
    wire dir_chg = eval_ok & (new_dir != dir_r);
    wire emerg = (cfg_i.run_mode_select == `DPDL_MODE_EMERG);
    wire gap_full = (gap_cnt_r == `DPDL_GAP_SILICON - 3'h1);

    always_ff @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            en_r <= EN_OFF;
            fsd_r <= 1'h0;
            fsd_at_dis_r <= 1'h0;
            mode_r <= `DPDL_MODE_NORMAL;
            mode_at_dis_r <= `DPDL_MODE_NORMAL;
            high_cnt_r <= '0;
            dir_r <= `DPDL_DIR_FWD;
            bwd_r <= `DPDL_DIR_FWD;
            lock_r <= 1'h0;
            gap_cnt_r <= '0;
            state_profile_value_pend_r <= 1'h0;
            state_profile_value_r <= '0;
        end else begin
            en_r <= en_nxt;
            mode_r <= cfg_i.run_mode_select;
            if (active & st_rise) fsd_r <= 1'h1;
            if (en_r == EN_RUN && !cfg_i.enable) begin
                fsd_at_dis_r <= fsd_r;
                mode_at_dis_r <= cfg_i.run_mode_select;
            end
            if (trg_rise) high_cnt_r <= '0;
            else if (trg_lvl && high_cnt_r != '1) high_cnt_r <= high_cnt_r + 1'b1;
            // Internal direction is held through a toggle, then discarded unless it sticks
            if (toggle_end && !reset_fails) dir_r <= `DPDL_DIR_FWD;
            else if (eval_ok) dir_r <= new_dir;
            // Status shows its reset value while paused, then follows the kept direction
            if (!active) bwd_r <= `DPDL_DIR_FWD;
            else if (eval_ok) bwd_r <= new_dir;
            else bwd_r <= dir_r;
            if (emerg && dir_chg) begin
                lock_r <= 1'h0;
                gap_cnt_r <= '0;
            end else if (active & st_rise) begin
                gap_cnt_r <= '0;
            end else if (active & gap_rise) begin
                if (gap_full) lock_r <= 1'h1;
                else gap_cnt_r <= gap_cnt_r + 1'b1;
            end
            if (mode_up) state_profile_value_pend_r <= 1'h1;
            else if (state_profile_value_pend_r & st_rise) state_profile_value_pend_r <= 1'h0;
            if (state_profile_value_pend_r & st_rise) state_profile_value_r <= trigger_profile_value_i;
        end
    end

    assign stat_o = '{backward_direction_status: bwd_r, lock_flag: lock_r,
        first_state_seen: fsd_r, state_profile_value: state_profile_value_r};
    assign internal_dir_o = dir_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    status_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (en_r == EN_PAUSE) |=> (bwd_r == `DPDL_DIR_FWD))
        else $error("status not reset while disabled");
    dir_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (en_r == EN_PAUSE && !cfg_i.enable) |=> $stable(dir_r))
        else $error("direction moved during toggle");
    lock_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (emerg && dir_chg) |=> !lock_r)
        else $error("lock not cleared on direction change");
    lock_gap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (active && gap_rise && gap_full && !dir_chg && !st_rise) |=> lock_r)
        else $error("lock not set after gaps");
    thr_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (active && trg_fall && !use_pin && thr_zero && !toggle_end) |=> $stable(dir_r))
        else $error("zero threshold changed direction");
    thr_max_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (active && trg_fall && !use_pin && thr_max) |=> (dir_r == `DPDL_DIR_FWD))
        else $error("max threshold did not force forward");
    pin_dir_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (eval_ok && use_pin && !toggle_end) |=> (dir_r == $past(dir_in_lvl)))
        else $error("direction not taken from channel");
    pin_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (active && trg_fall && use_pin && !pin_valid) |=> $stable(dir_r))
        else $error("channel direction taken with other mapping");
    state_profile_value_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (state_profile_value_pend_r && st_rise) |=> (state_profile_value_r == $past(trigger_profile_value_i)))
        else $error("state profile not loaded");
    mode_arm_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        mode_up |=> state_profile_value_pend_r)
        else $error("profile load not armed by mode change");
    toggle_rst_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (toggle_end && !reset_fails) |=> (dir_r == `DPDL_DIR_FWD))
        else $error("toggle did not reset direction");
    dir_report_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        eval_ok |=> (bwd_r == dir_r))
        else $error("status differs from evaluated direction");
    gap_restart_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (active && st_rise) |=> (gap_cnt_r == '0))
        else $error("gap count not restarted by state event");
    cov_lock_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b) $rose(lock_r));
    cov_bwd_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b) $rose(bwd_r));
    cov_toggle_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b) toggle_end);
    cov_state_profile_value_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b) state_profile_value_pend_r && st_rise);
    cov_refuse_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b)
        active && trg_fall && use_pin && !pin_valid);
endmodule
`default_nettype wire

// >>> hw/dpdl_cfg.svh
// Constants for the phase loop direction and lock control block.
// Assumes inclusion by bare name from the package; the modules do not include it.
`ifndef DPDL_CFG_SVH
`define DPDL_CFG_SVH
`define DPDL_TS_W 24
`define DPDL_PROF_W 24
`define DPDL_THR_MAX 24'h00ffff
`define DPDL_THR_ZERO 24'h000000
`define DPDL_GAP_W 3
`define DPDL_GAP_SPEC 3'h2
`define DPDL_GAP_SILICON 3'h4
`define DPDL_MODE_NORMAL 1'h0
`define DPDL_MODE_EMERG 1'h1
`define DPDL_DIR_FWD 1'h0
`define DPDL_DIR_BWD 1'h1
`define DPDL_MAP_DIRECT 2'h0
`endif

// >>> hw/dpdl_pkg.sv
// Types shared by the phase loop direction and lock control block.
// Assumes dpdl_cfg.svh is on the include path.
`include "dpdl_cfg.svh"
package dpdl_pkg;
    typedef struct packed {
        logic enable;
        logic run_mode_select;
        logic direction_source_select;
        logic combined_signal_mode;
        logic [1:0] trigger_map_select;
        logic [`DPDL_TS_W-1:0] min_high_threshold;
    } dpdl_cfg_s;
    typedef struct packed {
        logic backward_direction_status;
        logic lock_flag;
        logic first_state_seen;
        logic [`DPDL_PROF_W-1:0] state_profile_value;
    } dpdl_stat_s;
endpackage

// >>> hw/dpdl_edge_sync.sv
// Two-flop synchroniser with rise and fall pulses for one input signal.
// Assumes asynchronous input and an already synchronised active-low reset.
`timescale 1ns/10ps
`default_nettype none
module dpdl_edge_sync (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Signal
    input wire logic async_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= 1'h0;
            sync_r <= 1'h0;
            prev_r <= 1'h0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;
endmodule
`default_nettype wire

// >>> verif/dpdl_src_model.sv
// Behavioural model of the timer input channels feeding the block.
// Assumes the bench calls its tasks; every change lands by NBA on a rising edge.
`timescale 1ns/10ps
`default_nettype none
module dpdl_src_model (
    // Clock
    input wire logic sys_clk_i,
    // Signals towards the block
    output logic trigger_o,
    output logic state_o,
    output logic dir_chan_o,
    output logic gap_o
);
    logic [3:0] sig_r = 4'h0;
    assign trigger_o = sig_r[0];
    assign state_o = sig_r[1];
    assign dir_chan_o = sig_r[2];
    assign gap_o = sig_r[3];
    task automatic raise(input int idx);
        @(posedge sys_clk_i);
        sig_r[idx] <= 1'b1;
    endtask
    // Six idle cycles cover the synchroniser and the one-cycle answer
    task automatic fall(input int idx);
        @(posedge sys_clk_i);
        sig_r[idx] <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task automatic pulse(input int idx, input int width);
        raise(idx);
        repeat (width - 1) @(posedge sys_clk_i);
        fall(idx);
    endtask
endmodule
`default_nettype wire

// >>> verif/dpdl_top_tb.sv
// Self-checking bench for the phase loop direction and lock block.
// Assumes dpdl_pkg, dpdl_top and dpdl_src_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dpdl_top_tb;
    import dpdl_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    dpdl_cfg_s cfg = '0;
    logic [23:0] prof = 24'h0;
    logic trg, sta, dch, msf, idir, idir_w;
    dpdl_stat_s st, stat_w;
    int fail_count = 0;
    int checked = 0;
    int thr, w;
    always #2.5 sys_clk_i = ~sys_clk_i;
    dpdl_top dpdl_top_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg),
        .trigger_profile_value_i(prof), .trigger_i(trg), .state_i(sta),
        .direction_input_channel_i(dch), .missing_state_flag_i(msf),
        .stat_o(stat_w), .internal_dir_o(idir_w));
    dpdl_src_model dpdl_src_model_i (.sys_clk_i(sys_clk_i), .trigger_o(trg),
        .state_o(sta), .dir_chan_o(dch), .gap_o(msf));
    // Outputs are copied at the falling edge so checks never race the launching edge
    always @(negedge sys_clk_i) begin
        st <= stat_w;
        idir <= idir_w;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chkb(input string nm, input logic exp, input logic got);
        chk(nm, {23'h0, exp}, {23'h0, got});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic do_reset();
        rst_b_i <= 1'b0;
        cfg <= '0;
        tick(8);
        rst_b_i <= 1'b1;
        tick(4);
        chkb("bwd", 1'b0, st.backward_direction_status);
        chkb("lock", 1'b0, st.lock_flag);
        chkb("fsd", 1'b0, st.first_state_seen);
        cfg.min_high_threshold <= 24'h00000a;
        cfg.enable <= 1'b1;
        tick(3);
    endtask
    // The high-time counter starts one cycle after the synchronised rise
    function automatic logic exp_bwd(input int width, input int th);
        return (width - 1) < th;
    endfunction
    task automatic trig(input int width, input logic exp);
        dpdl_src_model_i.pulse(0, width);
        chkb("bwd", exp, st.backward_direction_status);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hdf62710d));
        do_reset();
        prof <= 24'($urandom);
        cfg.run_mode_select <= 1'b1;
        trig(30, 1'b0);
        chk("profile", 24'h0, st.state_profile_value);
        dpdl_src_model_i.pulse(1, 4);
        chk("profile", prof, st.state_profile_value);
        chkb("fsd", 1'b1, st.first_state_seen);
        cfg.run_mode_select <= 1'b0;
        $display("test mode change done");
        trig(3, 1'b1);
        dpdl_src_model_i.raise(0);
        tick(25);
        chkb("bwd mid", 1'b1, st.backward_direction_status);
        dpdl_src_model_i.fall(0);
        chkb("bwd", 1'b0, st.backward_direction_status);
        trig(3, 1'b1);
        cfg.enable <= 1'b0;
        tick(3);
        chkb("bwd off", 1'b0, st.backward_direction_status);
        chkb("dir off", 1'b1, idir);
        cfg.enable <= 1'b1;
        tick(3);
        chkb("bwd on", 1'b0, st.backward_direction_status);
        chkb("dir on", 1'b0, idir);
        $display("test toggle done");
        cfg.run_mode_select <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            dpdl_src_model_i.pulse(i == 3 ? 1 : 3, 2);
        end
        chkb("lock", 1'b0, st.lock_flag);
        dpdl_src_model_i.pulse(3, 2);
        chkb("lock", 1'b1, st.lock_flag);
        trig(3, 1'b1);
        chkb("lock", 1'b0, st.lock_flag);
        $display("test lock done");
        cfg.run_mode_select <= 1'b0;
        cfg.min_high_threshold <= 24'h000000;
        trig(30, 1'b1);
        cfg.min_high_threshold <= 24'h00ffff;
        trig(3, 1'b0);
        cfg.min_high_threshold <= 24'h000000;
        trig(3, 1'b0);
        // Threshold boundary: a high time equal to the threshold still counts as short
        cfg.min_high_threshold <= 24'h00000a;
        trig(10, exp_bwd(10, 10));
        trig(11, exp_bwd(11, 10));
        for (int i = 0; i < 16; i++) begin
            thr = 8 + int'($urandom % 60);
            w = 1 + int'($urandom % 80);
            if (w >= thr - 1 && w <= thr + 1) begin
                w = thr + 3;
            end
            cfg.min_high_threshold <= 24'(thr);
            trig(w, exp_bwd(w, thr));
        end
        $display("test threshold done");
        cfg.min_high_threshold <= 24'h00000a;
        cfg.direction_source_select <= 1'b1;
        dpdl_src_model_i.raise(2);
        trig(40, 1'b1);
        // Combined signal mode falls back to the threshold method
        cfg.combined_signal_mode <= 1'b1;
        trig(40, 1'b0);
        cfg.combined_signal_mode <= 1'b0;
        // Another trigger mapping refuses the channel, so the direction is held
        cfg.trigger_map_select <= 2'h1;
        trig(3, 1'b0);
        cfg.trigger_map_select <= 2'h0;
        trig(40, 1'b1);
        dpdl_src_model_i.fall(2);
        trig(3, 1'b0);
        $display("test channel done");
        do_reset();
        trig(3, 1'b1);
        cfg.enable <= 1'b0;
        tick(3);
        cfg.run_mode_select <= 1'b1;
        tick(2);
        cfg.enable <= 1'b1;
        tick(3);
        chkb("bwd kept", 1'b1, st.backward_direction_status);
        $display("test no state toggle done");
        wrap_up();
    end
endmodule
`default_nettype wire
